// *** jip_pkg.sv ***
// Package for the test-port programming block: instruction codes, array
// geometry, timing counts and state types.
// Assumes a 50 MHz system clock that samples the slow test-port pins.
package jip_pkg;

  // Instruction register and codes
  localparam int unsigned IR_W         = 4;
  localparam logic [3:0]  INS_UNLOCK   = 4'h9;
  localparam logic [3:0]  INS_ERASE    = 4'hA;
  localparam logic [3:0]  INS_PROGRAM  = 4'hB;
  localparam logic [3:0]  INS_READBACK = 4'hC;
  localparam logic [3:0]  INS_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;

  // Array geometry; shift register holds {row address, row data}
  localparam int unsigned ROW_W    = 16;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned NUM_ROWS = 16;
  localparam int unsigned SR_W     = ROW_W + ADDR_W;
  localparam int unsigned ADDR_LSB = ROW_W;
  localparam int unsigned FIFO_DEPTH = 4;

  // Timing: programming pulse lengths in their own units
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned ERASE_MS     = 100;
  localparam int unsigned PROGRAM_MS   = 10;
  localparam int unsigned ERASE_CYCLES   = CLK_HZ / 1000 * ERASE_MS;
  localparam int unsigned PROGRAM_CYCLES = CLK_HZ / 1000 * PROGRAM_MS;

  // Test access port states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
  } jip_tap_t;

  // Array write engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_ERASE, ENG_PROG} jip_eng_t;

endpackage

// *** jip_programmer.sv ***
// Test-port in-system programming logic with a small write queue and the
// nonvolatile row array it programs.
// Assumes test clock, mode select and data in arrive asynchronously and
// much slower than i_clock; i_rst comes from the power-up reset circuit.

// Queue between the shift path and the array write engine
module jip_fifo #(
  parameter int unsigned W     = 20,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } jip_fifo_st_t;

  jip_fifo_st_t   q_q;
  jip_fifo_st_t   q_d;
  logic [W-1:0]   mem [DEPTH];
  logic           push;
  logic           pop;

  // Full and empty come straight from the occupancy count
  assign o_in_ready  = (q_q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (q_q.cnt != '0);
  assign o_out_data  = mem[q_q.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer and count update; pointers wrap since DEPTH is a power of two
  always_comb
  begin
    q_d = q_q;
    if (push)
      q_d.wr = q_q.wr + 1'b1;
    if (pop)
      q_d.rd = q_q.rd + 1'b1;
    q_d.cnt = q_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      q_q <= '0;
    else
      q_q <= q_d;
  end

  // Storage carries no reset: only words behind the count are ever read
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[q_q.wr] <= i_in_data;
  end
endmodule

module jip_programmer #(
  parameter int unsigned P_ERASE_CYCLES   = jip_pkg::ERASE_CYCLES,
  parameter int unsigned P_PROGRAM_CYCLES = jip_pkg::PROGRAM_CYCLES
) (
  // Clock and power-up reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Test access port pins
  input  wire logic i_tck,
  input  wire logic i_tms,
  input  wire logic i_tdi,
  output logic      o_tdo,
  output logic      o_tdo_oe,
  // Status
  output logic      o_unlocked,
  output logic      o_busy
);
  localparam int unsigned SR_W   = jip_pkg::SR_W;
  localparam int unsigned ROW_W  = jip_pkg::ROW_W;
  localparam int unsigned ADDR_W = jip_pkg::ADDR_W;

  typedef struct packed {
    logic                tck_m;
    logic                tck_s;
    logic                tck_p;
    logic                tms_m;
    logic                tms_s;
    logic                tdi_m;
    logic                tdi_s;
    jip_pkg::jip_tap_t   tap;
    logic [3:0]          ir_sh;
    logic [3:0]          ir;
    logic                unlocked;
    logic [SR_W-1:0]     sr;
    logic                byp;
    logic                tdo;
    logic                tdo_oe;
    logic                erase_req;
    logic                prog_pend;
    logic [SR_W-1:0]     prog_word;
    jip_pkg::jip_eng_t   eng;
    logic [31:0]         cnt;
    logic [ADDR_W-1:0]   w_addr;
    logic [ROW_W-1:0]    w_data;
  } jip_st_t;

  jip_st_t           q_q;
  jip_st_t           q_d;
  logic [ROW_W-1:0]  rows [jip_pkg::NUM_ROWS];
  logic              rise;
  logic              fall;
  logic              isp_sel;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [SR_W-1:0]   fifo_out_data;
  logic              fifo_pop;
  logic              mem_we;
  logic              mem_clr;
  logic [ROW_W-1:0]  rd_word;

  // Next test-port state from mode select
  function automatic jip_pkg::jip_tap_t tap_next(jip_pkg::jip_tap_t s, logic m);
    case (s)
      jip_pkg::TAP_RESET:  tap_next = m ? jip_pkg::TAP_RESET  : jip_pkg::TAP_IDLE;
      jip_pkg::TAP_IDLE:   tap_next = m ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
      jip_pkg::TAP_SEL_DR: tap_next = m ? jip_pkg::TAP_SEL_IR : jip_pkg::TAP_CAP_DR;
      jip_pkg::TAP_CAP_DR: tap_next = m ? jip_pkg::TAP_EX1_DR : jip_pkg::TAP_SH_DR;
      jip_pkg::TAP_SH_DR:  tap_next = m ? jip_pkg::TAP_EX1_DR : jip_pkg::TAP_SH_DR;
      jip_pkg::TAP_EX1_DR: tap_next = m ? jip_pkg::TAP_UP_DR  : jip_pkg::TAP_PA_DR;
      jip_pkg::TAP_PA_DR:  tap_next = m ? jip_pkg::TAP_EX2_DR : jip_pkg::TAP_PA_DR;
      jip_pkg::TAP_EX2_DR: tap_next = m ? jip_pkg::TAP_UP_DR  : jip_pkg::TAP_SH_DR;
      jip_pkg::TAP_UP_DR:  tap_next = m ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
      jip_pkg::TAP_SEL_IR: tap_next = m ? jip_pkg::TAP_RESET  : jip_pkg::TAP_CAP_IR;
      jip_pkg::TAP_CAP_IR: tap_next = m ? jip_pkg::TAP_EX1_IR : jip_pkg::TAP_SH_IR;
      jip_pkg::TAP_SH_IR:  tap_next = m ? jip_pkg::TAP_EX1_IR : jip_pkg::TAP_SH_IR;
      jip_pkg::TAP_EX1_IR: tap_next = m ? jip_pkg::TAP_UP_IR  : jip_pkg::TAP_PA_IR;
      jip_pkg::TAP_PA_IR:  tap_next = m ? jip_pkg::TAP_EX2_IR : jip_pkg::TAP_PA_IR;
      jip_pkg::TAP_EX2_IR: tap_next = m ? jip_pkg::TAP_UP_IR  : jip_pkg::TAP_SH_IR;
      jip_pkg::TAP_UP_IR:  tap_next = m ? jip_pkg::TAP_SEL_DR : jip_pkg::TAP_IDLE;
      default:             tap_next = jip_pkg::TAP_RESET;
    endcase
  endfunction

  // Edges come from the second and third stages, never the first
  assign rise    = q_q.tck_s && !q_q.tck_p;
  assign fall    = !q_q.tck_s && q_q.tck_p;
  assign isp_sel = (q_q.ir == jip_pkg::INS_UNLOCK) || (q_q.ir == jip_pkg::INS_ERASE) ||
                   (q_q.ir == jip_pkg::INS_PROGRAM) || (q_q.ir == jip_pkg::INS_READBACK);
  assign rd_word = rows[q_q.sr[SR_W-1:jip_pkg::ADDR_LSB]];
  assign fifo_pop = (q_q.eng == jip_pkg::ENG_IDLE) && !q_q.erase_req;
  assign mem_clr = (q_q.eng == jip_pkg::ENG_ERASE) && (q_q.cnt == P_ERASE_CYCLES - 1);
  assign mem_we  = (q_q.eng == jip_pkg::ENG_PROG) && (q_q.cnt == P_PROGRAM_CYCLES - 1);
  assign o_tdo      = q_q.tdo;
  assign o_tdo_oe   = q_q.tdo_oe;
  assign o_unlocked = q_q.unlocked;
  assign o_busy     = (q_q.eng != jip_pkg::ENG_IDLE) || q_q.erase_req || q_q.prog_pend ||
                      fifo_out_valid;

  jip_fifo #(
    .W     (SR_W),
    .DEPTH (jip_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (q_q.prog_pend),
    .i_in_data   (q_q.prog_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_pop)
  );

  // Engine clears its requests first so a same-cycle new request wins
  always_comb
  begin
    q_d = q_q;
    q_d.tck_m = i_tck;
    q_d.tck_s = q_q.tck_m;
    q_d.tck_p = q_q.tck_s;
    q_d.tms_m = i_tms;
    q_d.tms_s = q_q.tms_m;
    q_d.tdi_m = i_tdi;
    q_d.tdi_s = q_q.tdi_m;
    if (q_q.prog_pend && fifo_in_ready)
      q_d.prog_pend = 1'b0;                                 // Queue full stalls the push
    case (q_q.eng)
      jip_pkg::ENG_IDLE:
      begin
        q_d.cnt = '0;
        if (q_q.erase_req)
        begin
          q_d.erase_req = 1'b0;
          q_d.eng       = jip_pkg::ENG_ERASE;
        end
        else if (fifo_out_valid)
        begin
          q_d.w_addr = fifo_out_data[SR_W-1:jip_pkg::ADDR_LSB];
          q_d.w_data = fifo_out_data[ROW_W-1:0];
          q_d.eng    = jip_pkg::ENG_PROG;
        end
      end
      jip_pkg::ENG_ERASE, jip_pkg::ENG_PROG:
      begin
        q_d.cnt = q_q.cnt + 32'h1;                          // Pulse timed on chip
        if (mem_clr || mem_we)
          q_d.eng = jip_pkg::ENG_IDLE;
      end
      default: q_d.eng = jip_pkg::ENG_IDLE;
    endcase
    // Test-port actions on the rising test clock
    if (rise)
    begin
      q_d.tap = tap_next(q_q.tap, q_q.tms_s);
      case (q_q.tap)
        jip_pkg::TAP_RESET:
        begin
          q_d.ir       = jip_pkg::INS_BYPASS;
          q_d.unlocked = 1'b0;
        end
        jip_pkg::TAP_CAP_IR: q_d.ir_sh = jip_pkg::IR_CAPTURE;
        jip_pkg::TAP_SH_IR:  q_d.ir_sh = {q_q.tdi_s, q_q.ir_sh[3:1]};
        jip_pkg::TAP_UP_IR:
        begin
          q_d.ir = q_q.ir_sh;
          if (q_q.ir_sh == jip_pkg::INS_UNLOCK)
            q_d.unlocked = 1'b1;
          if (q_q.ir_sh == jip_pkg::INS_ERASE && q_q.unlocked)
            q_d.erase_req = 1'b1;
        end
        jip_pkg::TAP_CAP_DR:
        begin
          q_d.byp = 1'b0;
          if (q_q.ir == jip_pkg::INS_READBACK && q_q.unlocked)
            q_d.sr[ROW_W-1:0] = rd_word;
        end
        jip_pkg::TAP_SH_DR:
        begin
          if (isp_sel)
            q_d.sr = {q_q.tdi_s, q_q.sr[SR_W-1:1]};
          else
            q_d.byp = q_q.tdi_s;
        end
        jip_pkg::TAP_UP_DR:
        begin
          if (q_q.ir == jip_pkg::INS_PROGRAM && q_q.unlocked)
          begin
            q_d.prog_pend = 1'b1;
            q_d.prog_word = q_q.sr;
          end
        end
        default: q_d.ir_sh = q_q.ir_sh;
      endcase
    end
    // Output changes on the falling test clock, off outside shifting
    if (fall)
    begin
      q_d.tdo_oe = (q_q.tap == jip_pkg::TAP_SH_IR) || (q_q.tap == jip_pkg::TAP_SH_DR);
      if (q_q.tap == jip_pkg::TAP_SH_IR)
        q_d.tdo = q_q.ir_sh[0];
      else if (q_q.tap == jip_pkg::TAP_SH_DR)
        q_d.tdo = isp_sel ? q_q.sr[0] : q_q.byp;
    end
  end

  // Power-up reset puts the port into its reset state
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      q_q     <= '0;
      q_q.tap <= jip_pkg::TAP_RESET;
      q_q.ir  <= jip_pkg::INS_BYPASS;
      q_q.eng <= jip_pkg::ENG_IDLE;
    end
    else
      q_q <= q_d;
  end

  // Array keeps its contents over reset, as a nonvolatile store would
  always_ff @(posedge i_clock)
  begin
    if (mem_clr)
    begin
      for (int i = 0; i < jip_pkg::NUM_ROWS; i++)
        rows[i] <= '0;
    end
    else if (mem_we)
      rows[q_q.w_addr] <= q_q.w_data;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_erase_go;
    q_q.erase_req && q_q.eng == jip_pkg::ENG_IDLE;
  endsequence
  sequence s_erase_run;
    q_q.eng == jip_pkg::ENG_ERASE ##1 q_q.eng == jip_pkg::ENG_ERASE;
  endsequence

  chk_unlock_sets: assert property (rise && q_q.tap == jip_pkg::TAP_UP_IR &&
    q_q.ir_sh == jip_pkg::INS_UNLOCK |=> q_q.unlocked)
    else $error("unlock not armed");
  chk_locked_no_erase: assert property (rise && q_q.tap == jip_pkg::TAP_UP_IR &&
    !q_q.unlocked && !q_q.erase_req && q_q.eng != jip_pkg::ENG_ERASE |=> !q_q.erase_req)
    else $error("erase accepted while locked");
  chk_erase_starts: assert property (s_erase_go |=> s_erase_run)
    else $error("erase did not start");
  chk_erase_clears: assert property (mem_clr |=> rows[0] == '0 &&
    q_q.eng == jip_pkg::ENG_IDLE)
    else $error("array not cleared");
  chk_prog_writes: assert property (mem_we |=>
    rows[$past(q_q.w_addr)] == $past(q_q.w_data))
    else $error("row not programmed");
  chk_readback_load: assert property (rise && q_q.tap == jip_pkg::TAP_CAP_DR &&
    q_q.ir == jip_pkg::INS_READBACK && q_q.unlocked |=> q_q.sr[ROW_W-1:0] == $past(rd_word))
    else $error("readback not loaded");
  chk_tdo_off_idle: assert property (fall && q_q.tap != jip_pkg::TAP_SH_DR &&
    q_q.tap != jip_pkg::TAP_SH_IR |=> !o_tdo_oe)
    else $error("output driven outside shift");
  chk_reset_state: assert property (rise && q_q.tap == jip_pkg::TAP_RESET |=>
    !q_q.unlocked && q_q.ir == jip_pkg::INS_BYPASS)
    else $error("reset state not applied");
endmodule

// *** jip_master.sv ***
// Test-port master model: walks the TAP and shifts scans LSB first.
// Assumes the bench clock paces it; the link clock stands still between frames.
module jip_master (
  // Pacing clock
  input  wire logic i_clock,
  // Device pins
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  timeunit 1ns;
  timeprecision 1ps;

  logic tdo_w;

  // Board pull-up holds a released data-out line high
  assign tdo_w = i_tdo_oe ? i_tdo : 1'b1;

  // Idle with mode select high so the TAP logic stays put
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // One 160 ns link clock, well under the 10 MHz limit
  // Data-out read late in the high phase
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clock);
    o_tck = 1'b1;
    repeat (4) @(negedge i_clock);
    tdo = tdo_w;
    o_tck = 1'b0;
  endtask

  // Five ticks high reach Test-Logic-Reset, one low parks in idle
  task automatic tap_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask

  // Idle to idle scan of n bits; ir picks the instruction path
  task automatic scan(input logic ir, input int n, input logic [19:0] din,
                      output logic [19:0] dout, output logic oe_all);
    logic b;
    dout = '0;
    oe_all = 1'b1;
    tick(1'b1, 1'b1, b);
    if (ir)
      tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
      oe_all = oe_all & i_tdo_oe;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule

// *** jip_programmer_bench.sv ***
// Self-checking bench for the test-port programming block and its queue.
// Assumes the master model paces the pins from the falling clock edge.
module jip_programmer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } jip_row_t;

  logic       clk;
  logic       rst;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdo_oe;
  logic       unlocked;
  logic       busy;
  int         err_total;
  int         tests_run;
  // Boundary addresses, a mid-range address and an all-ones word
  jip_row_t   rows [3] = '{'{4'h0, 16'hA5C3, 16'hA5C3}, '{4'hF, 16'hFFFF, 16'hFFFF},
                           '{4'h7, 16'h0001, 16'h0001}};

  // Short erase; program pulse long enough that six scans back up into the queue
  jip_programmer #(.P_ERASE_CYCLES(20), .P_PROGRAM_CYCLES(1100)) u_jip_programmer (
    .i_clock(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_unlocked(unlocked), .o_busy(busy));
  jip_master u_jip_master (
    .i_clock(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Bounded wait for the write engine to go quiet
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 8000)
    begin
      @(negedge clk);
      k++;
    end
    if (busy !== 1'b0)
    begin
      chk("busy timeout", 20'h0, 20'h1);
      wrap_up();
    end
  endtask

  task automatic ir(input logic [3:0] code);
    logic [19:0] q;
    logic        oe;
    u_jip_master.scan(1'b1, 4, {16'h0, code}, q, oe);
    chk("ir capture", {16'h0, jip_pkg::IR_CAPTURE}, q);
    chk("tdo enable in ir shift", 20'h1, {19'h0, oe});
  endtask

  // Address scan, then a second scan carries the captured row out
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [19:0] q;
    logic        oe;
    ir(jip_pkg::INS_READBACK);
    u_jip_master.scan(1'b0, 20, {a, 16'h0}, q, oe);
    u_jip_master.scan(1'b0, 20, {a, 16'h0}, q, oe);
    chk("readback", {4'h0, exp}, {4'h0, q[15:0]});
    chk("tdo enable in shift", 20'h1, {19'h0, oe});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [19:0] q;
    logic        oe;
    u_jip_master.scan(1'b0, 20, {a, d}, q, oe);
  endtask

  // Main sequence
  initial
  begin
    logic [19:0] q;
    logic        oe;
    err_total = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    chk("reset outputs", 20'h0, {16'h0, tdo, tdo_oe, unlocked, busy});
    rst = 1'b0;
    repeat (4) @(negedge clk);
    u_jip_master.tap_reset();
    chk("idle state", 20'h0, {18'h0, tdo_oe, unlocked});
    // Bypass after reset: one-bit delay with the captured zero in front
    u_jip_master.scan(1'b0, 4, 20'h5, q, oe);
    chk("bypass", 20'hA, q);
    ir(jip_pkg::INS_UNLOCK);
    chk("unlocked", 20'h1, {19'h0, unlocked});
    foreach (rows[i])
    begin
      ir(jip_pkg::INS_PROGRAM);
      wr(rows[i].addr, rows[i].wdata);
      wait_idle();
      rd(rows[i].addr, rows[i].exp);
    end
    // Bulk erase clears every row
    ir(jip_pkg::INS_ERASE);
    chk("erase busy", 20'h1, {19'h0, busy});
    wait_idle();
    foreach (rows[i])
      rd(rows[i].addr, 16'h0000);
    // TAP reset drops the unlock; program then goes nowhere
    u_jip_master.tap_reset();
    chk("relocked", 20'h0, {19'h0, unlocked});
    ir(jip_pkg::INS_PROGRAM);
    wr(4'h0, 16'hBEEF);
    chk("locked busy", 20'h0, {19'h0, busy});
    ir(jip_pkg::INS_UNLOCK);
    rd(4'h0, 16'h0000);
    // Six scans back to back: four words fill the queue, the sixth stalls until
    // the engine frees a slot; a shallower queue would lose the fifth word
    ir(jip_pkg::INS_PROGRAM);
    for (int i = 1; i < 7; i++)
      wr(i[3:0], {4{i[3:0]}});
    chk("queue busy", 20'h1, {19'h0, busy});
    wait_idle();
    for (int i = 1; i < 7; i++)
      rd(i[3:0], {4{i[3:0]}});
    // Power-up reset in mid-run drops the unlock; the array keeps its rows
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset relock", 20'h0, {17'h0, tdo_oe, unlocked, busy});
    rst = 1'b0;
    repeat (4) @(negedge clk);
    u_jip_master.tap_reset();
    ir(jip_pkg::INS_UNLOCK);
    rd(4'h6, 16'h6666);
    wrap_up();
  end
endmodule
